//--- wdg_base.sv
// Purpose: Time base giving one tick per second or per minute.
// Assumes: Restart aligns the unit boundary to the reload.
// Notes:   Tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.svh"
module wdg_base import wdg_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `WDG_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  // Core link
  wdg_tick_if.base  tb
);
  logic [31:0] cyc;
  logic [5:0]  sec;
  logic        tick;

  assign tb.tick = tick;

  // ==================================================================
  // Prescaler and second counter.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cyc  <= 32'h0000_0000;
      sec  <= 6'h00;
      tick <= 1'b0;
    end else if (tb.restart) begin
      cyc  <= 32'h0000_0000;
      sec  <= 6'h00;
      tick <= 1'b0;
    end else if (cyc == 32'(SEC_CYCLES - 1)) begin
      cyc  <= 32'h0000_0000;
      sec  <= (sec == 6'(`WDG_SEC_PER_MIN - 1)) ? 6'h00 : 6'(sec + 6'h01);
      tick <= tb.unit_sel | (sec == 6'(`WDG_SEC_PER_MIN - 1)); // R1
    end else begin
      cyc  <= 32'(cyc + 32'h0000_0001);
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- wdg_events_model.sv
// Purpose: Host-side activity and keyboard force sources for the watchdog.
// Assumes: Events change just after a rising clock edge.
// Notes:   Driven by calls from the testbench.
`timescale 1ns/1ps
`default_nettype none
module wdg_events_model (
  // Clock
  input  wire logic i_sys_clk,
  // Events
  output logic [2:0] o_reload_ev,
  output logic       o_force_line
);
  // ================================================================
  // Event drivers
  initial begin
    o_reload_ev  = 3'h0;
    o_force_line = 1'b0;
  end

  // One-cycle event on source k: game port, keyboard, mouse.
  task automatic pulse(input int k);
    @(posedge i_sys_clk);
    o_reload_ev <= 3'(1 << k);
    @(posedge i_sys_clk);
    o_reload_ev <= 3'h0;
  endtask

  // A raised line stays high for at least 1 us.
  task automatic line(input logic v);
    @(posedge i_sys_clk);
    o_force_line <= v;
    if (v) begin
      repeat (40) @(posedge i_sys_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- wdg_map.svh
// Purpose: Register indices, field positions, reset values and timing counts of the watchdog.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

// ====================================================================
// Register indices
`define WDG_IDX_UNITS     10'h052
`define WDG_IDX_VALUE     10'h053
`define WDG_IDX_CFG       10'h054
`define WDG_IDX_CTRL      10'h055
`define WDG_IDX_IRQ_ST    10'h060
`define WDG_IDX_IRQ_MASK  10'h061

// ====================================================================
// Field positions and codes
`define WDG_UNITS_SEL_BIT 7
`define WDG_CFG_GAME_BIT  0
`define WDG_CFG_KBD_BIT   1
`define WDG_CFG_MOUSE_BIT 2
`define WDG_CFG_MAP_LSB   4
`define WDG_CTL_STAT_BIT  0
`define WDG_CTL_FORCE_BIT 2
`define WDG_CTL_KBDEN_BIT 3
`define WDG_MAP_OFF       4'h0
`define WDG_MAP_BAD       4'h2
`define WDG_REG_RST       8'h00
`define WDG_RESP_OKAY     2'b00
`define WDG_RESP_SLVERR   2'b10

// ====================================================================
// Timing
`define WDG_CLK_PERIOD_NS 25
`define WDG_SEC_NS        1000000000
`define WDG_SEC_CYCLES    (`WDG_SEC_NS / `WDG_CLK_PERIOD_NS)
`define WDG_SEC_PER_MIN   60

`endif

//--- wdg_pkg.sv
// Purpose: Types shared by the watchdog modules.
// Assumes: Nothing.
// Notes:   Constants live in wdg_map.svh.
package wdg_pkg;
  // ==================================================================
  // Counter state, Gray coded along idle, count, expired.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_COUNT   = 2'b01,
    ST_EXPIRED = 2'b11
  } wdg_state_t;
endpackage

//--- wdg_tick_if.sv
// Purpose: Link between the watchdog core and its unit time base.
// Assumes: One clock domain.
// Notes:   None.
`timescale 1ns/1ps
`default_nettype none
interface wdg_tick_if;
  logic restart;
  logic unit_sel;
  logic tick;
  modport base (input restart, input unit_sel, output tick);
  modport core (output restart, output unit_sel, input tick);
endinterface
`default_nettype wire

//--- wdg_top.sv
// Purpose: Watchdog timer with AXI4-Lite registers and host interrupt mapping.
// Assumes: Reload and keyboard inputs are synchronous to i_sys_clk.
// Notes:   Only the low byte of each register word is used.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.svh"

// Function
// R1 - Units bit 0 counts minutes, 1 counts seconds.
// R2 - Timeout value zero keeps the watchdog disabled.
// R3 - Timeout value is a plain binary count of units.
// R4 - Game-port access restarts the count when enabled.
// R5 - Keyboard interrupt restarts the count when enabled.
// R6 - Mouse interrupt restarts the count when enabled.
// R7 - Mapping field picks host interrupt; zero disables, two is invalid.
// R8 - Status bit sets on timeout, reads zero while counting; a restart leaves it set until zero is written.
// R9 - Force bit produces a timeout and clears itself.
// R10 - Rising keyboard force line forces timeout when enabled.
// R11 - Edge pulse is ORed with the software force.
// R12 - Only the rising edge counts, never a held high level.
// R13 - Software writes zeros to upper reserved control bits.
// R14 - All four registers clear on reset, disabling the watchdog.
// R15 - Set status with valid mapping drives host interrupt; writing zero clears.
// R16 - Writing a value reloads; counter counts down to zero then times out.
module wdg_top import wdg_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `WDG_SEC_CYCLES,
  parameter int unsigned AW         = 12
) (
  // Clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst_b,
  // AXI4-Lite write
  input  wire logic [AW-1:0] i_awaddr,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  output logic [1:0]         o_bresp,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0] i_araddr,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  // Activity and force sources
  input  wire logic          i_gameport_access,
  input  wire logic          i_kbd_irq,
  input  wire logic          i_mouse_irq,
  input  wire logic          i_keyboard_ctrl_force_line,
  // Interrupts
  output logic [15:0]        o_host_irq,
  output logic               o_irq
);
  wdg_tick_if tb ();

  logic [AW-1:0] awaddr_q;
  logic [7:0]    wdata_q;
  logic          wstrb_q;
  logic          have_aw;
  logic          have_w;
  logic          do_write;
  logic          wr_hit;
  logic          unit_sel;
  logic [7:0]    value;
  logic [2:0]    reload_en;
  logic [3:0]    irq_map;
  logic          ctl_status;
  logic          ctl_kbd_en;
  logic          irq_st;
  logic          irq_mask;
  logic          force_sw;
  logic          force_kbd;
  logic          kbd_prev;
  logic          expire;
  logic          timeout_evt;
  logic          reload;
  logic [7:0]    next_value;
  logic [7:0]    cnt;
  wdg_state_t    state;
  logic [7:0]    rd_byte;
  logic          rd_hit;

  wdg_base #(.SEC_CYCLES(SEC_CYCLES)) u_base (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .tb        (tb.base)
  );

  // ==================================================================
  // Write channel: address and data taken in either order.
  assign do_write = have_aw & have_w & ~o_bvalid;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      have_aw   <= 1'b0;
      have_w    <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wstrb_q   <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `WDG_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        awaddr_q  <= i_awaddr;
        have_aw   <= 1'b1;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        wdata_q  <= i_wdata[7:0];
        wstrb_q  <= i_wstrb[0];
        have_w   <= 1'b1;
        o_wready <= 1'b0;
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        have_aw   <= 1'b0;
        have_w    <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  function automatic logic wsel(input logic [9:0] idx);
    wsel = do_write && wstrb_q && (awaddr_q[11:2] == idx);
  endfunction

  assign wr_hit = (awaddr_q[11:2] == `WDG_IDX_UNITS) || (awaddr_q[11:2] == `WDG_IDX_VALUE)
               || (awaddr_q[11:2] == `WDG_IDX_CFG) || (awaddr_q[11:2] == `WDG_IDX_CTRL)
               || (awaddr_q[11:2] == `WDG_IDX_IRQ_ST) || (awaddr_q[11:2] == `WDG_IDX_IRQ_MASK);

  // ==================================================================
  // Configuration registers.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      unit_sel   <= 1'b0; // R14
      value      <= `WDG_REG_RST;
      reload_en  <= 3'h0;
      irq_map    <= `WDG_MAP_OFF;
      ctl_kbd_en <= 1'b0;
      irq_mask   <= 1'b0;
    end else begin
      if (wsel(`WDG_IDX_UNITS)) begin
        unit_sel <= wdata_q[`WDG_UNITS_SEL_BIT]; // R1
      end
      if (wsel(`WDG_IDX_VALUE)) begin
        value <= wdata_q;
      end
      if (wsel(`WDG_IDX_CFG)) begin
        reload_en <= wdata_q[`WDG_CFG_MOUSE_BIT:`WDG_CFG_GAME_BIT];
        irq_map   <= wdata_q[`WDG_CFG_MAP_LSB +: 4];
      end
      if (wsel(`WDG_IDX_CTRL)) begin
        ctl_kbd_en <= wdata_q[`WDG_CTL_KBDEN_BIT]; // R13
      end
      if (wsel(`WDG_IDX_IRQ_MASK)) begin
        irq_mask <= wdata_q[0];
      end
    end
  end

  // ==================================================================
  // Force sources.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      force_sw  <= 1'b0;
      force_kbd <= 1'b0;
      kbd_prev  <= 1'b0;
    end else begin
      force_sw  <= wsel(`WDG_IDX_CTRL) && wdata_q[`WDG_CTL_FORCE_BIT]; // R9
      kbd_prev  <= i_keyboard_ctrl_force_line;
      force_kbd <= ctl_kbd_en && i_keyboard_ctrl_force_line && !kbd_prev; // R10 R12
    end
  end

  assign timeout_evt = expire | force_sw | force_kbd; // R11

  // ==================================================================
  // Countdown.
  assign next_value = wsel(`WDG_IDX_VALUE) ? wdata_q : value;
  assign reload = wsel(`WDG_IDX_VALUE) // R16
               | (reload_en[`WDG_CFG_GAME_BIT] & i_gameport_access) // R4
               | (reload_en[`WDG_CFG_KBD_BIT] & i_kbd_irq) // R5
               | (reload_en[`WDG_CFG_MOUSE_BIT] & i_mouse_irq); // R6
  assign tb.restart  = reload;
  assign tb.unit_sel = unit_sel;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state  <= ST_IDLE;
      cnt    <= 8'h00;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (reload) begin
        cnt   <= next_value; // R3
        state <= (next_value == 8'h00) ? ST_IDLE : ST_COUNT; // R2
      end else begin
        unique case (state)
          ST_IDLE: begin
            state <= ST_IDLE;
          end
          ST_COUNT: begin
            if (tb.tick) begin
              cnt <= 8'(cnt - 8'h01); // R16
              if (cnt == 8'h01) begin
                state  <= ST_EXPIRED;
                expire <= 1'b1;
              end
            end
          end
          ST_EXPIRED: begin
            state <= ST_EXPIRED;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==================================================================
  // Status and interrupts; a set wins over a clear.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_status <= 1'b0;
      irq_st     <= 1'b0;
      o_irq      <= 1'b0;
      o_host_irq <= 16'h0000;
    end else begin
      if (timeout_evt) begin
        ctl_status <= 1'b1; // R8
      end else if (wsel(`WDG_IDX_CTRL) && !wdata_q[`WDG_CTL_STAT_BIT]) begin
        ctl_status <= 1'b0; // R15
      end
      if (timeout_evt) begin
        irq_st <= 1'b1;
      end else if (wsel(`WDG_IDX_IRQ_ST) && wdata_q[0]) begin
        irq_st <= 1'b0;
      end
      o_irq <= irq_st & irq_mask;
      if (ctl_status && irq_map != `WDG_MAP_OFF && irq_map != `WDG_MAP_BAD) begin
        o_host_irq <= 16'(16'h0001 << irq_map); // R7 R15
      end else begin
        o_host_irq <= 16'h0000;
      end
    end
  end

  // ==================================================================
  // Read channel.
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    unique case (i_araddr[11:2])
      `WDG_IDX_UNITS:    rd_byte = {unit_sel, 7'h00};
      `WDG_IDX_VALUE:    rd_byte = value;
      `WDG_IDX_CFG:      rd_byte = {irq_map, 1'b0, reload_en};
      `WDG_IDX_CTRL:     rd_byte = {4'h0, ctl_kbd_en, 2'b00, ctl_status};
      `WDG_IDX_IRQ_ST:   rd_byte = {7'h00, irq_st};
      `WDG_IDX_IRQ_MASK: rd_byte = {7'h00, irq_mask};
      default:           rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `WDG_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= {24'h00_0000, rd_byte};
      o_rresp   <= rd_hit ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ==================================================================
  // Assertions.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  property p_zero_disabled;
    value == 8'h00 |-> state != ST_COUNT;
  endproperty
  a_zero_disabled: assert property (p_zero_disabled) else $error("Counting with value zero."); // R2

  property p_load;
    wsel(`WDG_IDX_VALUE) |=> cnt == $past(wdata_q);
  endproperty
  a_load: assert property (p_load) else $error("Counter not loaded with written value."); // R3

  property p_game;
    reload_en[0] && i_gameport_access && !wsel(`WDG_IDX_VALUE) |=> cnt == value;
  endproperty
  a_game: assert property (p_game) else $error("Game-port access did not restart count."); // R4

  property p_kbd;
    reload_en[1] && i_kbd_irq && !wsel(`WDG_IDX_VALUE) |=> cnt == value;
  endproperty
  a_kbd: assert property (p_kbd) else $error("Keyboard interrupt did not restart count."); // R5

  property p_mouse;
    reload_en[2] && i_mouse_irq && !wsel(`WDG_IDX_VALUE) |=> cnt == value;
  endproperty
  a_mouse: assert property (p_mouse) else $error("Mouse interrupt did not restart count."); // R6

  property p_bad_map;
    irq_map == `WDG_MAP_BAD || irq_map == `WDG_MAP_OFF |=> o_host_irq == 16'h0000 || $changed(irq_map);
  endproperty
  a_bad_map: assert property (p_bad_map) else $error("Host interrupt on disabled mapping."); // R7

  property p_expire;
    state == ST_COUNT && tb.tick && cnt == 8'h01 && !reload |=> expire ##1 ctl_status;
  endproperty
  a_expire: assert property (p_expire) else $error("Timeout did not set status."); // R8

  property p_self_clear;
    force_sw |=> !force_sw ##0 ctl_status;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("Force bit did not act and clear."); // R9

  property p_kbd_off;
    !ctl_kbd_en |=> !force_kbd;
  endproperty
  a_kbd_off: assert property (p_kbd_off) else $error("Disabled force line forced timeout."); // R10

  property p_level;
    i_keyboard_ctrl_force_line && kbd_prev |=> !force_kbd;
  endproperty
  a_level: assert property (p_level) else $error("Held force line forced timeout."); // R12

  property p_host_clear;
    !ctl_status |=> o_host_irq == 16'h0000;
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("Host interrupt without status."); // R15

  property p_down;
    state == ST_COUNT && tb.tick && cnt > 8'h01 && !reload |=> cnt == 8'($past(cnt) - 8'h01);
  endproperty
  a_down: assert property (p_down) else $error("Counter did not step down."); // R16
endmodule
`default_nettype wire

//--- wdg_top_test.sv
// Purpose: Self-checking testbench of the watchdog.
// Assumes: SEC_CYCLES is shortened to 8.
// Notes:   None.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.svh"
module wdg_top_test;
  // ================================================================
  // Signals
  localparam int          SC = 8;
  localparam logic [11:0] AU = {`WDG_IDX_UNITS, 2'b00};
  localparam logic [11:0] AV = {`WDG_IDX_VALUE, 2'b00};
  localparam logic [11:0] AC = {`WDG_IDX_CFG, 2'b00};
  localparam logic [11:0] AK = {`WDG_IDX_CTRL, 2'b00};
  localparam logic [11:0] AS = {`WDG_IDX_IRQ_ST, 2'b00};
  localparam logic [11:0] AM = {`WDG_IDX_IRQ_MASK, 2'b00};
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, fline;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  ev;
  logic [15:0] hirq;
  int          num_errors, cmp_count, cyc, n;

  wdg_top #(.SEC_CYCLES(SC), .AW(12)) i_dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_gameport_access(ev[0]),
    .i_kbd_irq(ev[1]), .i_mouse_irq(ev[2]), .i_keyboard_ctrl_force_line(fline),
    .o_host_irq(hirq), .o_irq(irq));

  wdg_events_model i_host (.i_sys_clk(clk), .o_reload_ev(ev), .o_force_line(fline));

  // ================================================================
  // Clock, timeout and shared tasks
  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
  endtask

  task automatic rd_(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
  endtask

  task automatic clr;
    wr(AV, 8'h00);
    wr(AC, 8'h00);
    wr(AK, 8'h00);
    wr(AS, 8'h01);
  endtask

  // ================================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rd_(AU + 12'(4 * i));
      chk(rd, 0);
    end
    rd_(12'h1F0);
    chk(rsp, 2'b10);
    wr(12'h1F0, 8'hFF);
    chk(rsp, 2'b10);
    $display("t_reset done");
  endtask

  task automatic t_irq;
    wr(AK, 8'h04);
    repeat (4) @(posedge clk);
    chk(irq, 0);
    rd_(AS);
    chk(rd, 1);
    wr(AM, 8'h01);
    repeat (3) @(posedge clk);
    chk(irq, 1);
    clr();
    repeat (3) @(posedge clk);
    chk(irq, 0);
    $display("t_irq done");
  endtask

  task automatic t_count(input logic [7:0] u, input logic [7:0] v);
    int t;
    t = int'(v) * (u[7] ? SC : 60 * SC);
    wr(AU, u);
    wr(AV, v);
    rd_(AK);
    chk(rd, 0);
    n = 0;
    while (irq !== 1'b1 && n < t + 8) begin
      @(posedge clk);
      n++;
    end
    chk(n, t + 1);
    rd_(AK);
    chk(rd, 1);
    clr();
    $display("t_count done");
  endtask

  task automatic t_zero;
    wr(AU, 8'h80);
    wr(AV, 8'h01);
    wr(AV, 8'h00);
    repeat (4 * SC) @(posedge clk);
    chk(irq, 0);
    $display("t_zero done");
  endtask

  task automatic t_reload;
    for (int k = 0; k < 3; k++) begin
      for (int e = 0; e < 2; e++) begin
        wr(AU, 8'h80);
        wr(AC, 8'(e << k));
        wr(AV, 8'h02);
        repeat (10) @(posedge clk);
        i_host.pulse(k);
        repeat (9) @(posedge clk);
        chk(irq, 1 - e);
        clr();
      end
    end
    $display("t_reload done");
  endtask

  task automatic t_map;
    logic [3:0] c [4] = '{4'h0, 4'h2, 4'h3, 4'hF};
    for (int i = 0; i < 4; i++) begin
      wr(AC, {c[i], 4'h0});
      wr(AK, 8'h04);
      repeat (4) @(posedge clk);
      rd_(AK);
      chk(rd, 1);
      chk(hirq, (c[i] == 0 || c[i] == 2) ? 0 : 32'(1 << c[i]));
      wr(AK, 8'h00);
      repeat (3) @(posedge clk);
      chk(hirq, 0);
      clr();
    end
    $display("t_map done");
  endtask

  task automatic t_line;
    wr(AK, 8'h08);
    i_host.line(1'b1);
    chk(irq, 1);
    wr(AK, 8'h08);
    wr(AS, 8'h01);
    repeat (5) @(posedge clk);
    chk(irq, 0);
    wr(AK, 8'h0C);
    repeat (4) @(posedge clk);
    chk(irq, 1);
    i_host.line(1'b0);
    clr();
    i_host.line(1'b1);
    chk(irq, 0);
    i_host.line(1'b0);
    $display("t_line done");
  endtask

  // ================================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h1;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_irq();
    t_count(8'h80, 8'h01);
    t_count(8'h80, 8'h03);
    t_count(8'h80, 8'hFF);
    t_count(8'h00, 8'h01);
    t_zero();
    t_reload();
    t_map();
    t_line();
    results();
  end
endmodule
`default_nettype wire
